// ===== hdl/cxo_pkg.sv
// package for the coexistence output block: register map, fields, resets,
// timing counts and shared types.
// assumes a 100 MHz clock and a 32-bit APB register bus.
`default_nettype none
package cxo_pkg;
  // timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned EXT_UNIT_NS   = 1000;
  // one extension unit is a least time, so it rounds up
  localparam int unsigned EXT_UNIT_CYC  =
    (EXT_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // register byte offsets
  localparam logic [7:0] OFS_REQ_POINTS  = 8'h00;
  localparam logic [7:0] OFS_DIR_POINTS  = 8'h04;
  localparam logic [7:0] OFS_PRIO_POINTS = 8'h08;
  localparam logic [7:0] OFS_SEQ_CTRL    = 8'h0C;
  localparam logic [7:0] OFS_COEX_CONTROL_REG   = 8'h10;
  localparam logic [7:0] OFS_MODE_CTRL   = 8'h14;
  localparam logic [7:0] OFS_STATUS      = 8'h18;
  localparam logic [7:0] OFS_IRQ_ENABLE  = 8'h1C;
  localparam logic [7:0] OFS_EXT_LEFT    = 8'h20;

  // sequence control fields
  localparam int SC_REQ_OVRD_EN  = 0;
  localparam int SC_REQ_OVRD_VAL = 1;
  localparam int SC_DIR_OVRD_EN  = 2;
  localparam int SC_DIR_OVRD_VAL = 3;
  localparam int SC_PRI_OVRD_EN  = 4;
  localparam int SC_PRI_OVRD_VAL = 5;
  localparam int SC_EXT_LSB      = 8;
  // coex control fields
  localparam int CC_SOURCE_SEL   = 0;
  // mode control fields
  localparam int MC_SRC_LSB      = 0;
  localparam int MC_WKUP_LSB     = 8;
  localparam int MC_IDLE_DIS     = 16;
  localparam int MC_FORCE        = 17;
  // status fields
  localparam int ST_FLAG         = 0;
  localparam int ST_PIN          = 1;
  localparam int ST_EXT          = 2;
  localparam int ST_AWAKE        = 3;
  // irq enable fields
  localparam int IE_REQ          = 0;

  // reset values
  localparam logic [31:0] RST_POINTS    = 32'h0000_0000;
  localparam logic [7:0]  RST_EXT_LEN   = 8'h00;
  localparam logic [5:0]  RST_WKUP_DLY  = 6'h00;

  typedef enum logic [1:0] {
    SRC_CTRL  = 2'b00,
    SRC_MUX   = 2'b01,
    SRC_LECLK = 2'b10,
    SRC_NONE  = 2'b11
  } cxo_src_type;

  typedef enum logic [1:0] {
    WK_SLEEP = 2'b00,
    WK_COUNT = 2'b01,
    WK_AWAKE = 2'b11
  } cxo_wake_type;

  // packed so that a register word maps straight onto it
  typedef struct packed {
    logic [7:0] tx_lo;
    logic [7:0] tx_hi;
    logic [7:0] rx_lo;
    logic [7:0] rx_hi;
  } cxo_points_type;
endpackage
`default_nettype wire

// ===== hdl/cxo_seq_if.sv
// interface carrying the sequence manager timing to the point generators.
// assumes the source drives all signals in the clk domain.
`default_nettype none
interface cxo_seq_if;
  logic [7:0] step;
  logic       rx_act;
  logic       tx_act;
  modport src  (output step, output rx_act, output tx_act);
  modport sink (input step, input rx_act, input tx_act);
endinterface
`default_nettype wire

// ===== hdl/cxo_point_gen.sv
// one sequence-timed coexistence output with software override.
// assumes step, rx_act and tx_act come from the sequence manager in clk.
`default_nettype none
module cxo_point_gen (
  input  wire logic                    clk,
  input  wire logic                    srst,
  input  wire logic                    ce,
  cxo_seq_if.sink                      seq,
  input  wire cxo_pkg::cxo_points_type pts,
  input  wire logic                    ovrd_en,
  input  wire logic                    ovrd_val,
  input  wire logic                    hold_in,
  output logic                         out
);
  typedef struct packed {
    logic timed;
    logic out;
  } cxo_pg_state_type;

  cxo_pg_state_type st_r;
  cxo_pg_state_type st_nxt;

  function automatic logic pt_hit(input logic [7:0] step,
                                  input logic [7:0] pt);
    return step == pt;
  endfunction

  always_comb begin
    st_nxt = st_r;
    // assert wins when both points are programmed to the same step
    if (seq.rx_act) begin
      if (pt_hit(seq.step, pts.rx_hi)) begin
        st_nxt.timed = 1'b1;
      end else if (pt_hit(seq.step, pts.rx_lo)) begin
        st_nxt.timed = 1'b0;
      end
    end else if (seq.tx_act) begin
      if (pt_hit(seq.step, pts.tx_hi)) begin
        st_nxt.timed = 1'b1;
      end else if (pt_hit(seq.step, pts.tx_lo)) begin
        st_nxt.timed = 1'b0;
      end
    end else begin
      st_nxt.timed = 1'b0;
    end
    // override replaces the timed value and any hold
    st_nxt.out = ovrd_en ? ovrd_val : (st_nxt.timed | hold_in);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign out = st_r.out;
endmodule
`default_nettype wire

// ===== hdl/cxo_top.sv
// coexistence output control: request, direction and priority to an
// external 2.4 GHz arbiter, with APB registers and one interrupt.
// assumes all inputs are synchronous to clk and ref_clk_32k is a slow
// level sampled in clk.
//
// Overview of operation
// - request timed by rx and tx points
// - request override replaces timed request value
// - extension holds request after sequence ends
// - one bit picks sequencer or link outputs
// - source field picks controller, mux, clock request
// - wake-up request after programmed 32 kHz ticks
// - idle-disable picks busy tracking or low-power
// - force bit holds controller request asserted
// - sticky flag on request rise, write-one clear
// - interrupt on request rise when enabled
// - direction timed by rx and tx points
// - direction override replaces timed value
// - sequencer priority upper bit reads zero
// - priority timed by rx and tx points
// - priority override forces a fixed level
// - idle-disable: request follows sequencer busy
// - extension starts at warm-down, zero ends it
`default_nettype none
module cxo_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [7:0]        seq_step,
  input  wire logic              seq_rx_active,
  input  wire logic              seq_tx_active,
  input  wire logic              seq_busy,
  input  wire logic              seq_warmdown_first,
  input  wire logic              ll_request,
  input  wire logic              ll_direction,
  input  wire logic [1:0]        ll_priority,
  input  wire logic              low_energy_clock_request,
  input  wire logic              xo_enable,
  input  wire logic              ref_clk_32k,
  input  wire logic              lp_sleep_request,
  output logic                   coex_request_out,
  output logic                   coex_direction_out,
  output logic      [1:0]        coex_priority_out,
  output logic                   irq
);
  localparam int PRE_W = $clog2(cxo_pkg::EXT_UNIT_CYC);
  localparam logic [PRE_W-1:0] PRE_LAST =
    PRE_W'(cxo_pkg::EXT_UNIT_CYC - 1);

  typedef struct packed {
    cxo_pkg::cxo_points_type req_pts;
    cxo_pkg::cxo_points_type dir_pts;
    cxo_pkg::cxo_points_type prio_pts;
    logic                    req_oen;
    logic                    req_oval;
    logic                    dir_oen;
    logic                    dir_oval;
    logic                    pri_oen;
    logic                    pri_oval;
    logic [7:0]              ext_len;
    logic                    coex_source_select;
    cxo_pkg::cxo_src_type    pin_src;
    logic [5:0]              wkup_dly;
    logic                    idle_dis;
    logic                    force_on;
    logic                    irq_en;
    logic                    flag;
    cxo_pkg::cxo_wake_type   wake;
    logic [5:0]              wk_cnt;
    logic                    ref_d;
    logic                    xo_d;
    logic                    ext_act;
    logic [7:0]              ext_left;
    logic [PRE_W-1:0]        ext_pre;
    logic                    pready;
    logic                    pslverr;
    logic [31:0]             prdata;
    logic                    req_pin;
    logic                    dir_pin;
    logic [1:0]              prio_pin;
    logic                    irq;
  } cxo_state_type;

  cxo_state_type st_r;
  cxo_state_type st_nxt;

  logic g_req;
  logic g_dir;
  logic g_prio;

  cxo_seq_if seq_bus ();

  assign seq_bus.step   = seq_step;
  assign seq_bus.rx_act = seq_rx_active;
  assign seq_bus.tx_act = seq_tx_active;

  // request generator: extension is ORed ahead of the override
  cxo_point_gen u_req (
    .clk      (clk),
    .srst     (srst),
    .ce       (ce),
    .seq      (seq_bus),
    .pts      (st_r.req_pts),
    .ovrd_en  (st_r.req_oen),
    .ovrd_val (st_r.req_oval),
    .hold_in  (st_r.ext_act),
    .out      (g_req)
  );

  cxo_point_gen u_dir (
    .clk      (clk),
    .srst     (srst),
    .ce       (ce),
    .seq      (seq_bus),
    .pts      (st_r.dir_pts),
    .ovrd_en  (st_r.dir_oen),
    .ovrd_val (st_r.dir_oval),
    .hold_in  (1'b0),
    .out      (g_dir)
  );

  cxo_point_gen u_prio (
    .clk      (clk),
    .srst     (srst),
    .ce       (ce),
    .seq      (seq_bus),
    .pts      (st_r.prio_pts),
    .ovrd_en  (st_r.pri_oen),
    .ovrd_val (st_r.pri_oval),
    .hold_in  (1'b0),
    .out      (g_prio)
  );

  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    logic [7:0] o;
    o = a[7:0];
    return (a[1:0] == 2'b00) &&
           ((o == cxo_pkg::OFS_REQ_POINTS) ||
            (o == cxo_pkg::OFS_DIR_POINTS) ||
            (o == cxo_pkg::OFS_PRIO_POINTS) ||
            (o == cxo_pkg::OFS_SEQ_CTRL) ||
            (o == cxo_pkg::OFS_COEX_CONTROL_REG) ||
            (o == cxo_pkg::OFS_MODE_CTRL) ||
            (o == cxo_pkg::OFS_STATUS) ||
            (o == cxo_pkg::OFS_IRQ_ENABLE) ||
            (o == cxo_pkg::OFS_EXT_LEFT));
  endfunction

  always_comb begin
    logic        wr_go;
    logic        w1c_flag;
    logic        ctrl_req;
    logic        mux_req;
    logic        mux_dir;
    logic [1:0]  mux_prio;
    logic [31:0] rd;
    logic [7:0]  off;
    wr_go    = 1'b0;
    w1c_flag = 1'b0;
    ctrl_req = 1'b0;
    mux_req  = 1'b0;
    mux_dir  = 1'b0;
    mux_prio = 2'b00;
    rd       = 32'h0000_0000;
    off      = paddr[7:0];
    st_nxt   = st_r;

    // apb: one wait state, write lands at the edge that sees pready
    st_nxt.pready = 1'b0;
    if (psel && penable && !st_r.pready) begin
      st_nxt.pready  = 1'b1;
      st_nxt.pslverr = !addr_ok(paddr);
      unique case (off)
        cxo_pkg::OFS_REQ_POINTS:  rd = st_r.req_pts;
        cxo_pkg::OFS_DIR_POINTS:  rd = st_r.dir_pts;
        cxo_pkg::OFS_PRIO_POINTS: rd = st_r.prio_pts;
        cxo_pkg::OFS_SEQ_CTRL: begin
          rd[cxo_pkg::SC_REQ_OVRD_EN]  = st_r.req_oen;
          rd[cxo_pkg::SC_REQ_OVRD_VAL] = st_r.req_oval;
          rd[cxo_pkg::SC_DIR_OVRD_EN]  = st_r.dir_oen;
          rd[cxo_pkg::SC_DIR_OVRD_VAL] = st_r.dir_oval;
          rd[cxo_pkg::SC_PRI_OVRD_EN]  = st_r.pri_oen;
          rd[cxo_pkg::SC_PRI_OVRD_VAL] = st_r.pri_oval;
          rd[cxo_pkg::SC_EXT_LSB +: 8] = st_r.ext_len;
        end
        cxo_pkg::OFS_COEX_CONTROL_REG: rd[cxo_pkg::CC_SOURCE_SEL] = st_r.coex_source_select;
        cxo_pkg::OFS_MODE_CTRL: begin
          rd[cxo_pkg::MC_SRC_LSB +: 2]  = st_r.pin_src;
          rd[cxo_pkg::MC_WKUP_LSB +: 6] = st_r.wkup_dly;
          rd[cxo_pkg::MC_IDLE_DIS]      = st_r.idle_dis;
          rd[cxo_pkg::MC_FORCE]         = st_r.force_on;
        end
        cxo_pkg::OFS_STATUS: begin
          rd[cxo_pkg::ST_FLAG]  = st_r.flag;
          rd[cxo_pkg::ST_PIN]   = st_r.req_pin;
          rd[cxo_pkg::ST_EXT]   = st_r.ext_act;
          rd[cxo_pkg::ST_AWAKE] = (st_r.wake == cxo_pkg::WK_AWAKE);
        end
        cxo_pkg::OFS_IRQ_ENABLE: rd[cxo_pkg::IE_REQ] = st_r.irq_en;
        cxo_pkg::OFS_EXT_LEFT:   rd[7:0] = st_r.ext_left;
        default:                 rd = 32'h0000_0000;
      endcase
      st_nxt.prdata = addr_ok(paddr) ? rd : 32'h0000_0000;
    end
    wr_go = psel && penable && st_r.pready && pwrite && addr_ok(paddr);

    if (wr_go) begin
      unique case (off)
        cxo_pkg::OFS_REQ_POINTS:  st_nxt.req_pts  = pwdata;
        cxo_pkg::OFS_DIR_POINTS:  st_nxt.dir_pts  = pwdata;
        cxo_pkg::OFS_PRIO_POINTS: st_nxt.prio_pts = pwdata;
        cxo_pkg::OFS_SEQ_CTRL: begin
          st_nxt.req_oen  = pwdata[cxo_pkg::SC_REQ_OVRD_EN];
          st_nxt.req_oval = pwdata[cxo_pkg::SC_REQ_OVRD_VAL];
          st_nxt.dir_oen  = pwdata[cxo_pkg::SC_DIR_OVRD_EN];
          st_nxt.dir_oval = pwdata[cxo_pkg::SC_DIR_OVRD_VAL];
          st_nxt.pri_oen  = pwdata[cxo_pkg::SC_PRI_OVRD_EN];
          st_nxt.pri_oval = pwdata[cxo_pkg::SC_PRI_OVRD_VAL];
          st_nxt.ext_len  = pwdata[cxo_pkg::SC_EXT_LSB +: 8];
        end
        cxo_pkg::OFS_COEX_CONTROL_REG: begin
          st_nxt.coex_source_select = pwdata[cxo_pkg::CC_SOURCE_SEL];
        end
        cxo_pkg::OFS_MODE_CTRL: begin
          st_nxt.pin_src  =
            cxo_pkg::cxo_src_type'(pwdata[cxo_pkg::MC_SRC_LSB +: 2]);
          st_nxt.wkup_dly = pwdata[cxo_pkg::MC_WKUP_LSB +: 6];
          st_nxt.idle_dis = pwdata[cxo_pkg::MC_IDLE_DIS];
          st_nxt.force_on = pwdata[cxo_pkg::MC_FORCE];
        end
        cxo_pkg::OFS_STATUS:     w1c_flag = pwdata[cxo_pkg::ST_FLAG];
        cxo_pkg::OFS_IRQ_ENABLE: st_nxt.irq_en = pwdata[cxo_pkg::IE_REQ];
        default: begin
        end
      endcase
    end

    // extension counts whole microseconds from the first warm-down step
    if (st_nxt.ext_len == 8'h00) begin
      st_nxt.ext_act  = 1'b0;
      st_nxt.ext_left = 8'h00;
    end else if (seq_warmdown_first) begin
      st_nxt.ext_act  = 1'b1;
      st_nxt.ext_left = st_nxt.ext_len;
      st_nxt.ext_pre  = '0;
    end else if (st_r.ext_act) begin
      if (st_r.ext_pre == PRE_LAST) begin
        st_nxt.ext_pre  = '0;
        st_nxt.ext_left = st_r.ext_left - 8'h01;
        if (st_r.ext_left == 8'h01) begin
          st_nxt.ext_act = 1'b0;
        end
      end else begin
        st_nxt.ext_pre = st_r.ext_pre + PRE_W'(1);
      end
    end

    // wake-up delay counted in rising edges of the 32 kHz reference
    st_nxt.ref_d = ref_clk_32k;
    st_nxt.xo_d  = xo_enable;
    if (lp_sleep_request || !xo_enable) begin
      st_nxt.wake = cxo_pkg::WK_SLEEP;
    end else begin
      unique case (st_r.wake)
        cxo_pkg::WK_SLEEP: begin
          if (!st_r.xo_d) begin
            st_nxt.wake   = cxo_pkg::WK_COUNT;
            st_nxt.wk_cnt = 6'h00;
          end
        end
        cxo_pkg::WK_COUNT: begin
          if (st_r.wk_cnt >= st_r.wkup_dly) begin
            st_nxt.wake = cxo_pkg::WK_AWAKE;
          end else if (ref_clk_32k && !st_r.ref_d) begin
            st_nxt.wk_cnt = st_r.wk_cnt + 6'h01;
          end
        end
        cxo_pkg::WK_AWAKE: st_nxt.wake = cxo_pkg::WK_AWAKE;
        default:           st_nxt.wake = cxo_pkg::WK_SLEEP;
      endcase
    end

    // controller request
    if (st_r.idle_dis) begin
      ctrl_req = seq_busy;
    end else begin
      ctrl_req = (st_r.wake == cxo_pkg::WK_AWAKE);
    end
    ctrl_req = ctrl_req | st_r.force_on;

    // direction and priority switch source together; request takes mux_req only when pin_src is SRC_MUX
    if (st_r.coex_source_select) begin
      mux_req  = ll_request;
      mux_dir  = ll_direction;
      mux_prio = ll_priority;
    end else begin
      mux_req  = g_req;
      mux_dir  = g_dir;
      mux_prio = {1'b0, g_prio};
    end

    unique case (st_r.pin_src)
      cxo_pkg::SRC_CTRL:  st_nxt.req_pin = ctrl_req;
      cxo_pkg::SRC_MUX:   st_nxt.req_pin = mux_req;
      cxo_pkg::SRC_LECLK: st_nxt.req_pin = low_energy_clock_request;
      cxo_pkg::SRC_NONE:  st_nxt.req_pin = 1'b0;
    endcase
    st_nxt.dir_pin  = mux_dir;
    st_nxt.prio_pin = mux_prio;

    // a rise in the same cycle as the clear keeps the flag set
    st_nxt.flag = (st_r.flag & ~w1c_flag) |
                  (st_nxt.req_pin & ~st_r.req_pin);
    st_nxt.irq  = st_nxt.flag & st_nxt.irq_en;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r          <= '0;
      st_r.req_pts  <= cxo_pkg::RST_POINTS;
      st_r.dir_pts  <= cxo_pkg::RST_POINTS;
      st_r.prio_pts <= cxo_pkg::RST_POINTS;
      st_r.ext_len  <= cxo_pkg::RST_EXT_LEN;
      st_r.wkup_dly <= cxo_pkg::RST_WKUP_DLY;
      st_r.pin_src  <= cxo_pkg::SRC_CTRL;
      st_r.wake     <= cxo_pkg::WK_SLEEP;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign prdata             = st_r.prdata;
  assign pready             = st_r.pready;
  assign pslverr            = st_r.pslverr;
  assign coex_request_out   = st_r.req_pin;
  assign coex_direction_out = st_r.dir_pin;
  assign coex_priority_out  = st_r.prio_pin;
  assign irq                = st_r.irq;
endmodule
`default_nettype wire

// ===== sim/cxo_top_assertions.sv
// checker for cxo_top outputs against its mode and select bits.
// assumes control bits change only by completed APB writes.
`default_nettype none
module cxo_top_assertions #(
  parameter int ADDR_W = 8
) (
  input wire logic              clk,
  input wire logic              srst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic              seq_busy,
  input wire logic              ll_request,
  input wire logic              ll_direction,
  input wire logic [1:0]        ll_priority,
  input wire logic              low_energy_clock_request,
  input wire logic              coex_request_out,
  input wire logic              coex_direction_out,
  input wire logic [1:0]        coex_priority_out,
  input wire logic              irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       sel_r, idis_r, frc_r, ie_r, rst_r;
  logic [1:0] src_r;
  logic       wr;
  assign wr = psel && penable && pready && pwrite;
  // shadow of the control bits; rst_r masks the edge after a short reset
  always_ff @(posedge clk) begin
    rst_r <= srst;
    if (srst) begin
      {sel_r, idis_r, frc_r, ie_r, src_r} <= '0;
    end else if (wr) begin
      if (paddr == ADDR_W'(cxo_pkg::OFS_COEX_CONTROL_REG)) begin
        sel_r <= pwdata[0];
      end
      if (paddr == ADDR_W'(cxo_pkg::OFS_MODE_CTRL)) begin
        src_r  <= pwdata[1:0];
        idis_r <= pwdata[16];
        frc_r  <= pwdata[17];
      end
      if (paddr == ADDR_W'(cxo_pkg::OFS_IRQ_ENABLE)) begin
        ie_r <= pwdata[0];
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst || rst_r);
  property p_le_src;
    $past(src_r) == 2'b10 |->
      coex_request_out == $past(low_energy_clock_request);
  endproperty
  a_le_src: assert property (p_le_src) else $error("le source");
  property p_none_src;
    $past(src_r) == 2'b11 |-> !coex_request_out;
  endproperty
  a_none_src: assert property (p_none_src) else $error("src 3");
  property p_mux_req;
    $past(src_r) == 2'b01 && $past(sel_r) |->
      coex_request_out == $past(ll_request);
  endproperty
  a_mux_req: assert property (p_mux_req) else $error("ll req");
  property p_mux_dir;
    $past(sel_r) |-> coex_direction_out == $past(ll_direction);
  endproperty
  a_mux_dir: assert property (p_mux_dir) else $error("ll dir");
  property p_mux_prio;
    $past(sel_r) |-> coex_priority_out == $past(ll_priority);
  endproperty
  a_mux_prio: assert property (p_mux_prio) else $error("ll prio");
  property p_prio_hi;
    !$past(sel_r) |-> !coex_priority_out[1];
  endproperty
  a_prio_hi: assert property (p_prio_hi) else $error("prio1");
  property p_force;
    $past(src_r) == 2'b00 && $past(frc_r) |-> coex_request_out;
  endproperty
  a_force: assert property (p_force) else $error("force");
  property p_idle_dis;
    $past(src_r) == 2'b00 && $past(idis_r) && !$past(frc_r) |->
      coex_request_out == $past(seq_busy);
  endproperty
  a_idle_dis: assert property (p_idle_dis) else $error("busy");
  property p_irq_rise;
    // irq is registered with the enable that lands on the same edge
    $rose(coex_request_out) && ie_r |-> irq;
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq");
  property p_irq_off;
    !ie_r |-> !irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq off");
  c_le: cover property ($past(src_r) == 2'b10 && coex_request_out);
  c_force: cover property ($past(frc_r) && coex_request_out);
  c_irq: cover property ($rose(irq));
endmodule
bind cxo_top cxo_top_assertions #(.ADDR_W(ADDR_W)) i_cxo_top_assertions (
  .clk(clk), .srst(srst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .seq_busy(seq_busy), .ll_request(ll_request),
  .ll_direction(ll_direction), .ll_priority(ll_priority),
  .low_energy_clock_request(low_energy_clock_request),
  .coex_request_out(coex_request_out),
  .coex_direction_out(coex_direction_out),
  .coex_priority_out(coex_priority_out), .irq(irq));
`default_nettype wire

// ===== sim/cxo_arbiter_model.sv
// model of the external 2.4 GHz arbiter that watches the outputs.
// assumes request, direction and priority are clk domain levels.
`default_nettype none
module cxo_arbiter_model (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       request,
  input  wire logic       direction,
  input  wire logic [1:0] prio,
  output logic      [7:0] req_rises,
  output logic            high_prio_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic req_q;
  // no grant path: the block under test has no grant input
  always @(posedge clk) begin
    req_q <= srst ? 1'b0 : request;
    if (srst) begin
      req_rises <= 8'h00;
      high_prio_seen <= 1'b0;
    end else begin
      req_rises <= req_rises + 8'(request && !req_q);
      high_prio_seen <= high_prio_seen | (request & direction & prio[1]);
    end
  end
endmodule
`default_nettype wire

// ===== sim/cxo_top_test.sv
// self-checking bench for cxo_top: APB tasks for the registers and
// direct drive of the sequencer, link layer and mode inputs.
// assumes the one wait state APB answer of cxo_top.
`default_nettype none
module cxo_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, srst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr, step, rises;
  logic [31:0] pwdata, prdata, rd;
  logic        rxa, txa, busy, wdf, llr, lld, le, xo, r32, lps;
  logic        req, dir, irq, hps;
  logic [1:0]  llp, prio;
  int          num_errors, cmp_count, cyc;
  logic [63:0] stp = 64'h0706_0403_0605_0302;
  logic [7:0]  ex = 8'h66;

  cxo_top i_cxo_top (
    .clk(clk), .srst(srst), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .seq_step(step),
    .seq_rx_active(rxa), .seq_tx_active(txa), .seq_busy(busy),
    .seq_warmdown_first(wdf), .ll_request(llr), .ll_direction(lld),
    .ll_priority(llp), .low_energy_clock_request(le), .xo_enable(xo),
    .ref_clk_32k(r32), .lp_sleep_request(lps), .coex_request_out(req),
    .coex_direction_out(dir), .coex_priority_out(prio), .irq(irq));
  cxo_arbiter_model i_cxo_arbiter_model (
    .clk(clk), .srst(srst), .request(req), .direction(dir),
    .prio(prio), .req_rises(rises), .high_prio_seen(hps));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      $display("ERROR %0t timeout", $time);
      test_done();
    end
  end

  task automatic test_done();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one idle cycle after each transfer keeps psel from double assignment
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      $display("ERROR %0t no pready", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic pulse();
    wdf <= 1'b1;
    tick(1);
    wdf <= 1'b0;
  endtask
  task automatic rise32();
    r32 <= 1'b1;
    tick(3);
    r32 <= 1'b0;
    tick(3);
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata, step} = '0;
    {rxa, txa, busy, wdf, llr, lld, llp, le, xo, r32, lps} = '0;
    srst = 1'b1;
    tick(5);
    srst <= 1'b0;
    tick(1);
    apb(1'b0, 8'h24, 32'h0);
    chk(err, 32'h1);
    chk(rd, 32'h0);
    rc(cxo_pkg::OFS_MODE_CTRL, 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr(cxo_pkg::OFS_REQ_POINTS + 8'(4 * i), 32'h0704_0603);
    end
    wr(cxo_pkg::OFS_MODE_CTRL, 32'h1);
    for (int i = 0; i < 8; i++) begin
      rxa <= (i < 4);
      txa <= (i >= 4);
      step <= stp[i*8 +: 8];
      tick(3);
      chk(req, ex[i]);
      chk(dir, ex[i]);
      chk(prio, {1'b0, ex[i]});
    end
    rxa <= 1'b0;
    txa <= 1'b0;
    tick(3);
    chk(req, 32'h0);
    wr(cxo_pkg::OFS_SEQ_CTRL, 32'h15);
    rxa <= 1'b1;
    step <= 8'h03;
    tick(3);
    chk(req, 32'h0);
    chk(dir, 32'h0);
    chk(prio, 32'h0);
    wr(cxo_pkg::OFS_SEQ_CTRL, 32'h3F);
    tick(3);
    chk(req, 32'h1);
    chk(dir, 32'h1);
    chk(prio, 32'h1);
    rxa <= 1'b0;
    wr(cxo_pkg::OFS_SEQ_CTRL, 32'h100);
    pulse();
    tick(50);
    chk(req, 32'h1);
    tick(60);
    chk(req, 32'h0);
    pulse();
    tick(20);
    wr(cxo_pkg::OFS_SEQ_CTRL, 32'h0);
    tick(3);
    chk(req, 32'h0);
    pulse();
    tick(3);
    chk(req, 32'h0);
    wr(cxo_pkg::OFS_COEX_CONTROL_REG, 32'h1);
    llr <= 1'b1;
    lld <= 1'b1;
    llp <= 2'b10;
    tick(3);
    chk(req, 32'h1);
    chk(dir, 32'h1);
    chk(prio, 32'h2);
    le <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      wr(cxo_pkg::OFS_MODE_CTRL, 32'(s));
      tick(3);
      chk(req, 32'(s == 1 || s == 2));
    end
    llr <= 1'b0;
    wr(cxo_pkg::OFS_MODE_CTRL, 32'h2_0000);
    tick(3);
    chk(req, 32'h1);
    wr(cxo_pkg::OFS_MODE_CTRL, 32'h1_0000);
    tick(3);
    chk(req, 32'h0);
    busy <= 1'b1;
    tick(3);
    chk(req, 32'h1);
    busy <= 1'b0;
    wr(cxo_pkg::OFS_MODE_CTRL, 32'h200);
    xo <= 1'b1;
    tick(2);
    rise32();
    chk(req, 32'h0);
    rise32();
    chk(req, 32'h1);
    lps <= 1'b1;
    tick(3);
    chk(req, 32'h0);
    wr(cxo_pkg::OFS_STATUS, 32'h1);
    rc(cxo_pkg::OFS_STATUS, 32'h0);
    wr(cxo_pkg::OFS_MODE_CTRL, 32'h2_0000);
    tick(3);
    chk(irq, 32'h0);
    rc(cxo_pkg::OFS_STATUS, 32'h3);
    rc(cxo_pkg::OFS_STATUS, 32'h3);
    wr(cxo_pkg::OFS_IRQ_ENABLE, 32'h1);
    tick(2);
    chk(irq, 32'h1);
    wr(cxo_pkg::OFS_STATUS, 32'h1);
    tick(2);
    chk(irq, 32'h0);
    rc(cxo_pkg::OFS_STATUS, 32'h2);
    wr(cxo_pkg::OFS_MODE_CTRL, 32'h0);
    tick(3);
    wr(cxo_pkg::OFS_MODE_CTRL, 32'h2_0000);
    tick(3);
    chk(irq, 32'h1);
    chk(32'(rises != 8'h00), 32'h1);
    chk(hps, 32'h1);
    test_done();
  end
endmodule
`default_nettype wire
